// file: core/irg_core.sv
`timescale 1ns/1ps
module irg_core #(
    parameter irg_pkg::irg_port_mode_t PORT_MODE = irg_pkg::IRG_PORT_PINS_0123,
    parameter int unsigned PIN_HOLD_CYC = 32'(irg_pkg::PIN_HOLD_CYC),
    parameter int unsigned PORT_HOLD_CYC = 32'(irg_pkg::PORT_HOLD_CYC),
    parameter int unsigned OSC_STOP_CYC = 32'(irg_pkg::OSC_STOP_CYC)
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic osc_clk_i,
    input wire logic reset_pin_i,
    input wire logic [3:0] input_port_pins_i,
    output logic init_reset_o,
    output logic fetch_start_o,
    output logic [7:0] program_counter_step_o,
    output logic [3:0] program_counter_page_o,
    output logic [3:0] next_page_pointer_o,
    output logic int_flag_o,
    output logic dec_flag_o
);

    localparam logic [irg_pkg::CNT_W-1:0] OSC_STOP_V = irg_pkg::CNT_W'(OSC_STOP_CYC);

    logic osc_prev_q; // oscillator level one cycle ago
    logic osc_primed_q; // previous level holds a real sample, not the reset value
    logic osc_edge; // oscillator toggled this cycle
    logic [irg_pkg::CNT_W-1:0] osc_idle_q; // cycles since the last oscillator edge
    logic osc_stopped_q; // oscillation-stop detector output
    logic [3:0] port_mask; // pins taking part in the port reset
    logic port_all; // every selected pin high at once
    logic pin_accept; // filtered reset pin request
    logic port_accept; // filtered port combination request
    logic reset_req; // combined initial reset request
    logic init_reset_q; // registered initial reset
    logic fetch_start_q; // one-cycle start pulse after release
    logic [7:0] pc_step_q; // program counter step
    logic [3:0] pc_page_q; // program counter page
    logic [3:0] next_page_q; // new page pointer
    logic int_flag_q; // interrupt flag
    logic dec_flag_q; // decimal flag

    // oscillator edge detection, the pin is sampled as a plain input
    // the primed flag keeps a stopped oscillator parked high from faking a toggle after reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_prev_q <= 1'b0;
            osc_primed_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_clk_i;
            osc_primed_q <= 1'b1;
        end
    end

    // either oscillator edge counts as oscillation, once a real sample is held
    assign osc_edge = osc_primed_q & (osc_clk_i ^ osc_prev_q);

    // idle watchdog, cleared by each oscillator edge
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_idle_q <= '0;
        end else if (osc_edge) begin
            osc_idle_q <= '0;
        end else if (osc_idle_q != OSC_STOP_V) begin
            osc_idle_q <= osc_idle_q + 1'b1;
        end
    end

    // detector starts out stopped: power-on counts as no oscillation yet
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_stopped_q <= 1'b1;
        end else if (osc_edge) begin
            osc_stopped_q <= 1'b0;
        end else if (osc_idle_q == OSC_STOP_V) begin
            osc_stopped_q <= 1'b1;
        end
    end

    // build-time pin selection; a disabled option can never fire
    always_comb begin
        case (PORT_MODE)
            irg_pkg::IRG_PORT_NONE: port_mask = irg_pkg::PORT_MASK_NONE;
            irg_pkg::IRG_PORT_PINS_01: port_mask = irg_pkg::PORT_MASK_01;
            irg_pkg::IRG_PORT_PINS_012: port_mask = irg_pkg::PORT_MASK_012;
            irg_pkg::IRG_PORT_PINS_0123: port_mask = irg_pkg::PORT_MASK_0123;
            default: port_mask = irg_pkg::PORT_MASK_NONE;
        endcase
    end

    // logical AND of the selected pins
    assign port_all = (port_mask != irg_pkg::PORT_MASK_NONE) &&
                      ((input_port_pins_i & port_mask) == port_mask);

    // reset pin noise rejection
    irg_filter #(
        .COUNT(PIN_HOLD_CYC)
    ) u_pin_filter (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .cond_i(reset_pin_i),
        .accepted_o(pin_accept)
    );

    // port combination noise rejection; long hold guards against key bounce
    irg_filter #(
        .COUNT(PORT_HOLD_CYC)
    ) u_port_filter (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .cond_i(port_all),
        .accepted_o(port_accept)
    );

    // any source asserts the reset
    assign reset_req = osc_stopped_q | pin_accept | port_accept;

    // initial reset, released once all sources drop
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_reset_q <= 1'b1;
        end else begin
            init_reset_q <= reset_req;
        end
    end

    // start pulse in the first cycle out of reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fetch_start_q <= 1'b0;
        end else begin
            fetch_start_q <= init_reset_q & ~reset_req;
        end
    end

    // processor state loaded while reset is requested, held otherwise
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_step_q <= irg_pkg::PC_STEP_INIT;
            pc_page_q <= irg_pkg::PC_PAGE_INIT;
            next_page_q <= irg_pkg::NEXT_PAGE_INIT;
            int_flag_q <= irg_pkg::INT_FLAG_INIT;
            dec_flag_q <= irg_pkg::DEC_FLAG_INIT;
        end else if (reset_req) begin
            pc_step_q <= irg_pkg::PC_STEP_INIT;
            pc_page_q <= irg_pkg::PC_PAGE_INIT;
            next_page_q <= irg_pkg::NEXT_PAGE_INIT;
            int_flag_q <= irg_pkg::INT_FLAG_INIT;
            dec_flag_q <= irg_pkg::DEC_FLAG_INIT;
        end
    end

    // every output straight from its register
    assign init_reset_o = init_reset_q;
    assign fetch_start_o = fetch_start_q;
    assign program_counter_step_o = pc_step_q;
    assign program_counter_page_o = pc_page_q;
    assign next_page_pointer_o = next_page_q;
    assign int_flag_o = int_flag_q;
    assign dec_flag_o = dec_flag_q;

    // checks on the request and release paths
    property p_any_source;
        @(posedge clock_i) disable iff (!rst_n_i)
        (osc_stopped_q || pin_accept || port_accept) |=> init_reset_o;
    endproperty
    a_any_source: assert property (p_any_source) else $error("request did not reset");

    property p_osc_hold;
        @(posedge clock_i) disable iff (!rst_n_i)
        (osc_stopped_q && !osc_edge) |=> osc_stopped_q ##1 init_reset_o;
    endproperty
    a_osc_hold: assert property (p_osc_hold) else $error("stopped oscillator lost reset");

    property p_pin_cause;
        @(posedge clock_i) disable iff (!rst_n_i)
        pin_accept |-> $past(reset_pin_i);
    endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("pin accepted while low");

    property p_pin_release;
        @(posedge clock_i) disable iff (!rst_n_i)
        (!reset_pin_i && !port_all && !osc_stopped_q && !osc_edge && !port_accept &&
         (osc_idle_q != OSC_STOP_V)) |=> !pin_accept ##1 !init_reset_o;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("reset not released");

    property p_port_cause;
        @(posedge clock_i) disable iff (!rst_n_i)
        port_accept |-> $past(port_all, 1);
    endproperty
    a_port_cause: assert property (p_port_cause) else $error("port reset without pins");

    property p_port_and;
        @(posedge clock_i) disable iff (!rst_n_i)
        port_all == ((PORT_MODE == irg_pkg::IRG_PORT_PINS_01) ? (&input_port_pins_i[1:0]) :
                     (PORT_MODE == irg_pkg::IRG_PORT_PINS_012) ? (&input_port_pins_i[2:0]) :
                     (PORT_MODE == irg_pkg::IRG_PORT_PINS_0123) ? (&input_port_pins_i[3:0]) : 1'b0);
    endproperty
    a_port_and: assert property (p_port_and) else $error("port combination wrong");

    property p_init_values;
        @(posedge clock_i) disable iff (!rst_n_i)
        init_reset_o |-> (program_counter_step_o == irg_pkg::PC_STEP_INIT) &&
                         (program_counter_page_o == irg_pkg::PC_PAGE_INIT) &&
                         (next_page_pointer_o == irg_pkg::NEXT_PAGE_INIT) &&
                         (int_flag_o == irg_pkg::INT_FLAG_INIT) && (dec_flag_o == irg_pkg::DEC_FLAG_INIT);
    endproperty
    a_init_values: assert property (p_init_values) else $error("reset values wrong");

    property p_fetch_start;
        @(posedge clock_i) disable iff (!rst_n_i)
        fetch_start_o |-> !init_reset_o && $past(init_reset_o) &&
                          (program_counter_page_o == irg_pkg::PC_PAGE_INIT) &&
                          (program_counter_step_o == irg_pkg::PC_STEP_INIT);
    endproperty
    a_fetch_start: assert property (p_fetch_start) else $error("start address wrong");

endmodule

// file: core/irg_pkg.sv
// shared constants for the initial reset generator
package irg_pkg;

    // clock period of clock_i in ns (100 MHz)
    localparam longint unsigned CLK_PERIOD_NS = 64'd10;

    // least hold time of the reset pin: 5 ms
    localparam longint unsigned PIN_HOLD_MS = 64'd5;
    localparam longint unsigned PIN_HOLD_NS = PIN_HOLD_MS * 64'd1000000;
    // least time rounds up to whole cycles
    localparam longint unsigned PIN_HOLD_CYC = (PIN_HOLD_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;

    // least hold time of the input port combination: 4 s
    localparam longint unsigned PORT_HOLD_S = 64'd4;
    localparam longint unsigned PORT_HOLD_NS = PORT_HOLD_S * 64'd1000000000;
    localparam longint unsigned PORT_HOLD_CYC = (PORT_HOLD_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;

    // no oscillator edge for this long means the oscillator has stopped
    localparam longint unsigned OSC_STOP_NS = 64'd100000;
    localparam longint unsigned OSC_STOP_CYC = (OSC_STOP_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;

    // width of the noise rejection and watchdog counters
    localparam int unsigned CNT_W = 32;

    // build-time choice of the input port reset combination
    typedef enum logic [1:0] {
        IRG_PORT_NONE,
        IRG_PORT_PINS_01,
        IRG_PORT_PINS_012,
        IRG_PORT_PINS_0123
    } irg_port_mode_t;

    // masks of the input port pins for each combination
    localparam logic [3:0] PORT_MASK_NONE = 4'h0;
    localparam logic [3:0] PORT_MASK_01 = 4'h3;
    localparam logic [3:0] PORT_MASK_012 = 4'h7;
    localparam logic [3:0] PORT_MASK_0123 = 4'hf;

    // processor state loaded by the initial reset
    localparam logic [7:0] PC_STEP_INIT = 8'h00;
    localparam logic [3:0] PC_PAGE_INIT = 4'h1;
    localparam logic [3:0] NEXT_PAGE_INIT = 4'h1;
    localparam logic INT_FLAG_INIT = 1'b0;
    localparam logic DEC_FLAG_INIT = 1'b0;

endpackage

// file: core/irg_filter.sv
`timescale 1ns/1ps
// noise rejection: accepted only after cond_i held high for COUNT cycles
module irg_filter #(
    parameter int unsigned COUNT = 1
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cond_i,
    output logic accepted_o
);

    localparam logic [irg_pkg::CNT_W-1:0] COUNT_V = irg_pkg::CNT_W'(COUNT);

    logic [irg_pkg::CNT_W-1:0] cnt_q; // cycles the condition has held

    // counter restarts as soon as the condition drops, saturates at the target
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (!cond_i) begin
            cnt_q <= '0;
        end else if (cnt_q != COUNT_V) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // accepted drops the cycle after the condition goes away
    assign accepted_o = (cnt_q == COUNT_V);

    property p_fil_count;
        @(posedge clock_i) disable iff (!rst_n_i)
        (cond_i && !accepted_o) |=> (cnt_q == $past(cnt_q) + 1'b1);
    endproperty
    a_fil_count: assert property (p_fil_count) else $error("filter counter did not advance");

    property p_fil_restart;
        @(posedge clock_i) disable iff (!rst_n_i)
        !cond_i |=> (cnt_q == '0) && !accepted_o;
    endproperty
    a_fil_restart: assert property (p_fil_restart) else $error("filter did not restart");

endmodule

// file: tb/irg_board.sv
`timescale 1ns/1ps
// board side: oscillator, reset pin driver and input port drivers
module irg_board #(
    parameter int unsigned HALF_CYC = 4
) (
    input wire logic clock_i,
    input wire logic osc_run_i,
    input wire logic pin_req_i,
    input wire logic [3:0] port_req_i,
    output logic osc_clk_o,
    output logic reset_pin_o,
    output logic [3:0] port_pins_o
);
    logic [7:0] div_q = 8'h00; // half period count
    logic osc_q = 1'b0; // oscillator level
    assign osc_clk_o = osc_q;
    // oscillator; a stopped crystal holds its level, it does not toggle
    always @(posedge clock_i) begin
        if (!osc_run_i) begin
            div_q <= 8'h00;
        end else if (div_q == 8'(HALF_CYC - 1)) begin
            div_q <= 8'h00;
            osc_q <= ~osc_q;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    // pins follow the requests; all ports high only when commanded
    always @(posedge clock_i) begin
        reset_pin_o <= pin_req_i;
        port_pins_o <= port_req_i;
    end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
// one core per port combination, all fed by one board model
module testbench;
    localparam int unsigned PIN_CYC = 5; // shortened pin filter
    localparam int unsigned PORT_CYC = 8; // shortened port filter
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic osc_run = 1'b1; // oscillator enable
    logic pin_req = 1'b0;
    logic [3:0] port_req = 4'h0;
    logic osc_clk;
    logic reset_pin;
    logic [3:0] port_pins;
    logic init_w [4]; // indexed by combination
    logic fetch_w [4];
    logic [7:0] step_w [4];
    logic [3:0] page_w [4];
    logic [3:0] npp_w [4];
    logic int_w [4];
    logic dec_w [4];
    logic [3:0] masks [4] = '{4'h0, 4'h3, 4'h7, 4'hf}; // selected pins
    int error_cnt = 0;
    int checks = 0;

    // 100 MHz clock
    always #5 clock_i = ~clock_i;

    irg_board board (.clock_i(clock_i), .osc_run_i(osc_run), .pin_req_i(pin_req), .port_req_i(port_req),
        .osc_clk_o(osc_clk), .reset_pin_o(reset_pin), .port_pins_o(port_pins));

    // every build-time combination side by side
    for (genvar m = 0; m < 4; m++) begin : g_mode
        irg_core #(.PORT_MODE(irg_pkg::irg_port_mode_t'(m)), .PIN_HOLD_CYC(PIN_CYC), .PORT_HOLD_CYC(PORT_CYC),
            .OSC_STOP_CYC(20)) uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .osc_clk_i(osc_clk),
            .reset_pin_i(reset_pin), .input_port_pins_i(port_pins), .init_reset_o(init_w[m]),
            .fetch_start_o(fetch_w[m]), .program_counter_step_o(step_w[m]), .program_counter_page_o(page_w[m]),
            .next_page_pointer_o(npp_w[m]), .int_flag_o(int_w[m]), .dec_flag_o(dec_w[m]));
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // wait n edges, then let their updates land
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    // processor state as loaded by the initial reset
    task automatic state_check();
        check({step_w[3], page_w[3], npp_w[3], int_w[3], dec_w[3]}, {8'h00, 4'h1, 4'h1, 2'b00});
    endtask

    // bounded wait for the one-cycle release pulse
    task automatic wait_fetch(input int bound);
        int i;
        for (i = 0; i < bound && fetch_w[3] !== 1'b1; i++) tick(1);
        if (fetch_w[3] !== 1'b1) begin
            check(1, 0);
            end_of_test();
        end
        check({init_w[3], step_w[3], page_w[3]}, {1'b0, 8'h00, 4'h1});
        tick(1);
        check(fetch_w[3], 0);
    endtask

    // reset pin request: exact filter length, release timing
    task automatic t_pin();
        @(posedge clock_i);
        pin_req <= 1'b1;
        tick(PIN_CYC + 1);
        check(init_w[3], 0);
        tick(1);
        check(init_w[3], 1);
        tick(3);
        state_check();
        @(posedge clock_i);
        pin_req <= 1'b0;
        tick(2);
        check(init_w[3], 1);
        tick(1);
        check({init_w[3], fetch_w[3]}, 2'b01);
        tick(1);
        check(fetch_w[3], 0);
    endtask

    // two short pulses with one low cycle between must not reset
    task automatic t_short();
        int seen;
        seen = 0;
        repeat (2) begin
            @(posedge clock_i);
            pin_req <= 1'b1;
            repeat (PIN_CYC - 1) @(posedge clock_i);
            pin_req <= 1'b0;
        end
        repeat (8) begin
            tick(1);
            if (init_w[3] !== 1'b0) seen++;
        end
        check(seen, 0);
    endtask

    // port patterns against every combination; 4'he lacks pin 0
    task automatic t_port();
        logic [3:0] pats [4] = '{4'h3, 4'h7, 4'hf, 4'he};
        for (int p = 0; p < 4; p++) begin
            @(posedge clock_i);
            port_req <= pats[p];
            tick(PORT_CYC + 1);
            for (int m = 0; m < 4; m++) check(init_w[m], 0);
            tick(1);
            for (int m = 0; m < 4; m++) check(init_w[m], masks[m] != 0 && (pats[p] & masks[m]) == masks[m]);
            @(posedge clock_i);
            port_req <= 4'h0;
            tick(4);
            for (int m = 0; m < 4; m++) check(init_w[m], 0);
        end
    endtask

    // oscillator stops, then restarts
    task automatic t_osc();
        int i;
        @(posedge clock_i);
        osc_run <= 1'b0;
        tick(12);
        check(init_w[3], 0);
        for (i = 0; i < 30 && init_w[3] !== 1'b1; i++) tick(1);
        check(init_w[3], 1);
        if (init_w[3] !== 1'b1) end_of_test();
        state_check();
        @(posedge clock_i);
        osc_run <= 1'b1;
        wait_fetch(20);
    endtask

    // mid-run reset: detector starts out stopped, release waits for a fresh toggle
    task automatic t_rst();
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        tick(1);
        check({init_w[3], fetch_w[3]}, 2'b10);
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        #1;
        check(init_w[3], 1);
        state_check();
        wait_fetch(40);
    endtask

    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        #1;
        check(init_w[3], 1);
        state_check();
        wait_fetch(40);
        $display("power-up test done");
        t_pin();
        $display("pin test done");
        t_short();
        $display("short pulse test done");
        t_port();
        $display("port test done");
        t_osc();
        $display("oscillator test done");
        t_rst();
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule
